// [logic/frt_timer.v]
// Purpose: free-running 16-bit timer counter core with byte views
// Assumes: inputs synchronous to clk; cpu drives the register port
// Notes:   no capture/compare; halt and wait come in as levels

`include "frt_defs.vh"

module frt_timer #(
   parameter EXT_BONDED = 1
) (
   // clock and reset
   input  wire       clk,
   input  wire       nrst,
   // register port
   input  wire [3:0] addr,
   input  wire [7:0] wdata,
   input  wire       wr,
   input  wire       rd,
   output reg  [7:0] rdata,
   // system
   input  wire       irq_mask,
   input  wire       halt_mode,
   input  wire       wait_mode,
   input  wire       external_tick_pin,
   output reg        wrap_irq
);

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   reg  [15:0] count_q;
   reg  [7:0]  lo_latch_q;
   reg         latched_q;
   reg         wrap_flag_q;
   reg         armed_q;
   reg         wrap_irq_enable_q;
   reg  [1:0]  tick_source_select_q;
   reg         external_edge_select_q;
   reg  [2:0]  presc_q;
   reg         ext_neg_q;
   reg         ext_s1_q;
   reg         ext_s2_q;
   reg         ext_prev_q;

   // an unbonded pin must read as one
   wire ext_pin = (EXT_BONDED != 0) ? external_tick_pin : 1'b1;

   // -----------------------------------------------------------------
   // external edge path
   // -----------------------------------------------------------------
   // first stage on the falling edge, the counter sees it only after
   // two rising-edge stages; caller keeps the source below clk/4
   always @(negedge clk or negedge nrst) begin
      if (!nrst)
         ext_neg_q <= 1'b1;
      else
         ext_neg_q <= ext_pin;
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ext_s1_q   <= 1'b1;
         ext_s2_q   <= 1'b1;
         ext_prev_q <= 1'b1;
      end else begin
         ext_s1_q   <= ext_neg_q;
         ext_s2_q   <= ext_s1_q;
         ext_prev_q <= ext_s2_q;
      end
   end

   wire ext_rise = ext_s2_q & ~ext_prev_q;
   wire ext_fall = ~ext_s2_q & ext_prev_q;
   wire ext_edge = external_edge_select_q ? ext_rise : ext_fall;

   // -----------------------------------------------------------------
   // prescaler
   // -----------------------------------------------------------------
   reg tick;
   always @* begin
      case (tick_source_select_q)
         2'h0:    tick = presc_q[0];
         2'h1:    tick = presc_q[1:0] == 2'h3;
         2'h2:    tick = presc_q == 3'h7;
         default: tick = ext_edge;
      endcase
   end

   wire run = ~halt_mode; // wait has no effect, halt freezes
   wire adv = run & tick;

   // -----------------------------------------------------------------
   // decode
   // -----------------------------------------------------------------
   wire acc_lo_main = (rd | wr) & (addr == `FRT_OFS_CNT_LO);
   wire acc_lo_shd  = (rd | wr) & (addr == `FRT_OFS_SHD_LO);
   wire rd_hi       = rd & ((addr == `FRT_OFS_CNT_HI) | (addr == `FRT_OFS_SHD_HI));
   wire rd_lo       = rd & ((addr == `FRT_OFS_CNT_LO) | (addr == `FRT_OFS_SHD_LO));
   wire wr_lo       = wr & ((addr == `FRT_OFS_CNT_LO) | (addr == `FRT_OFS_SHD_LO));
   wire wrap        = adv & (count_q == 16'hffff) & ~wr_lo;

   // -----------------------------------------------------------------
   // counter and control
   // -----------------------------------------------------------------
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count_q                <= `FRT_RELOAD;
         presc_q                <= 3'h0;
         wrap_irq_enable_q      <= 1'b0;
         tick_source_select_q   <= 2'h0;
         external_edge_select_q <= 1'b0;
      end else begin
         if (run)
            presc_q <= presc_q + 3'h1;
         if (wr_lo)
            count_q <= `FRT_RELOAD;
         else if (adv)
            count_q <= count_q + 16'h0001;
         if (wr && addr == `FRT_OFS_CTRL_ONE)
            wrap_irq_enable_q <= wdata[`FRT_BIT_WRAP_IE];
         if (wr && addr == `FRT_OFS_CTRL_TWO) begin
            tick_source_select_q   <= wdata[`FRT_LSB_TICK_SEL+1:`FRT_LSB_TICK_SEL];
            external_edge_select_q <= wdata[`FRT_BIT_EXT_EDGE];
         end
      end
   end

   // -----------------------------------------------------------------
   // read latch and wrap flag
   // -----------------------------------------------------------------
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lo_latch_q  <= 8'h00;
         latched_q   <= 1'b0;
         wrap_flag_q <= 1'b0;
         armed_q     <= 1'b0;
      end else begin
         if (rd_hi && !latched_q) begin
            lo_latch_q <= count_q[7:0];
            latched_q  <= 1'b1;
         end else if (rd_lo)
            latched_q <= 1'b0;
         if (rd && addr == `FRT_OFS_STATUS && wrap_flag_q)
            armed_q <= 1'b1;
         else if (acc_lo_main)
            armed_q <= 1'b0;
         // set wins over clear; shadow access never clears
         if (wrap)
            wrap_flag_q <= 1'b1;
         else if (acc_lo_main && armed_q && !acc_lo_shd)
            wrap_flag_q <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // read data and interrupt
   // -----------------------------------------------------------------
   reg [7:0] rmux;
   always @* begin
      case (addr)
         `FRT_OFS_CTRL_ONE: rmux = {wrap_irq_enable_q, 7'h00};
         `FRT_OFS_CTRL_TWO: rmux = {4'h0, tick_source_select_q, 1'b0, external_edge_select_q};
         `FRT_OFS_STATUS:   rmux = {2'h0, wrap_flag_q, 5'h00};
         `FRT_OFS_CNT_HI,
         `FRT_OFS_SHD_HI:   rmux = count_q[15:8];
         `FRT_OFS_CNT_LO,
         `FRT_OFS_SHD_LO:   rmux = latched_q ? lo_latch_q : count_q[7:0];
         default:           rmux = 8'h00;
      endcase
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata    <= 8'h00;
         wrap_irq <= 1'b0;
      end else begin
         rdata    <= rd ? rmux : 8'h00;
         wrap_irq <= wrap_flag_q & wrap_irq_enable_q & ~irq_mask;
      end
   end

endmodule // frt_timer

// [logic/frt_defs.vh]
// Purpose: constants for the free-running 16-bit timer counter core
// Assumes: byte-wide register port, one 200 MHz clock
// Notes:   offsets are byte indices on the plain register port
//
// How it works
// - sixteen-bit upcounter advanced by prescaler tick
// - tick rate cpu/2, /4, /8 or external
// - both select bits one picks external edge
// - external edges synchronised on falling cpu edge
// - main and shadow views, identical values
// - low byte write forces count to fffc
// - reset loads fffc, only reload value
// - high read first latches low byte
// - latched low byte held until low read
// - lone low read returns live low byte
// - wrap from ffff to 0000 sets flag
// - irq when flag, enable, mask clear
// - status read then main low access clears
// - shadow low access never clears flag
// - wait mode does not stop counting
// - halt freezes count, resumes from it
// - unbonded pin input reads as one
`ifndef FRT_DEFS_VH
`define FRT_DEFS_VH

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define FRT_OFS_CTRL_ONE    4'h0
`define FRT_OFS_CTRL_TWO    4'h1
`define FRT_OFS_STATUS      4'h2
`define FRT_OFS_CNT_HI      4'h3
`define FRT_OFS_CNT_LO      4'h4
`define FRT_OFS_SHD_HI      4'h5
`define FRT_OFS_SHD_LO      4'h6

// -----------------------------------------------------------------
// fields and values
// -----------------------------------------------------------------
`define FRT_BIT_WRAP_IE     7
`define FRT_BIT_WRAP_FLAG   5
`define FRT_BIT_EXT_EDGE    0
`define FRT_LSB_TICK_SEL    2
`define FRT_RELOAD          16'hfffc
`define FRT_TICK_EXT        2'h3

`endif

// [tb/frt_timer_assertions.sv]
// Purpose: port assertions for frt_timer
// Assumes: status bit 5 shows the wrap flag
// Notes:   bound to every frt_timer
module frt_timer_assertions (
   // clock
   input wire       clk,
   input wire       nrst,
   // bus
   input wire [3:0] addr,
   input wire [7:0] wdata,
   input wire       wr,
   input wire       rd,
   input wire [7:0] rdata,
   // misc
   input wire       irq_mask,
   input wire       halt_mode,
   input wire       wait_mode,
   input wire       external_tick_pin,
   input wire       wrap_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_ld; wr && (addr == 4'h4 || addr == 4'h6); endsequence
   sequence s_hi; rd && (addr == 4'h3 || addr == 4'h5); endsequence
   property p_reload; s_ld ##1 s_hi |=> rdata == 8'hff; endproperty
   a_reload: assert property (p_reload) else $error("reload");
   property p_latch; s_ld ##1 s_hi[*3] ##1 (rd && addr == 4'h6) |=> rdata == 8'hfc; endproperty
   a_latch: assert property (p_latch) else $error("latch");
   property p_live; (halt_mode && wr && addr == 4'h4) ##1 halt_mode ##1 (rd && addr == 4'h6)
      |=> rdata == 8'hfc; endproperty
   a_live: assert property (p_live) else $error("live");
   property p_halt; (halt_mode && rd && addr == 4'h3) ##1 (halt_mode && rd && addr == 4'h5)
      |=> rdata == $past(rdata); endproperty
   a_halt: assert property (p_halt) else $error("halt");
   property p_mask; irq_mask |=> !wrap_irq; endproperty
   a_mask: assert property (p_mask) else $error("mask");
   property p_rise; $rose(wrap_irq) |-> !$past(irq_mask); endproperty
   a_rise: assert property (p_rise) else $error("rise");
   property p_clr; (rd && addr == 4'h2) ##1 (rd && addr == 4'h4 && rdata[5]) ##1 (rd && addr == 4'h2)
      |=> !rdata[5]; endproperty
   a_clr: assert property (p_clr) else $error("clear");
   property p_keep; (rd && addr == 4'h2) ##1 (rd && addr == 4'h6 && rdata[5]) ##1 (rd && addr == 4'h2)
      |=> rdata[5]; endproperty
   a_keep: assert property (p_keep) else $error("keep");
endmodule // frt_timer_assertions

bind frt_timer frt_timer_assertions u_chk (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
   .rd(rd), .rdata(rdata), .irq_mask(irq_mask), .halt_mode(halt_mode), .wait_mode(wait_mode),
   .external_tick_pin(external_tick_pin), .wrap_irq(wrap_irq));

// [tb/frt_tick_src.sv]
// Purpose: external tick source
// Assumes: go changes just after a clk edge
// Notes:   pin idles high, toggles every 4 clk
module frt_tick_src (
   // ports
   input  wire  clk,
   input  wire  go,
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] ph_q = 2'h0;
   initial pin = 1'b1;
   // period of 8 clk stays under a quarter of the cpu rate
   always @(posedge clk) begin
      if (go) begin
         ph_q <= ph_q + 2'h1;
         if (ph_q == 2'h3) pin <= ~pin;
      end
   end
endmodule // frt_tick_src

// [tb/test_frt_timer.sv]
// Purpose: bench for frt_timer
// Assumes: halt freezes count and prescaler
// Notes:   each run adds 8 ticks from fffc
module test_frt_timer;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, nrst, wr, rd, irq_mask, halt_mode, wait_mode, go, pin, wrap_irq;
   logic [3:0] addr;
   logic [7:0] wdata, rdata;
   int n_errors = 0, n_checks = 0, n_cyc = 0;
   localparam logic [7:0] CTL [5] = '{8'h00, 8'h04, 8'h08, 8'h0d, 8'h0c};
   frt_timer u_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .irq_mask(irq_mask), .halt_mode(halt_mode), .wait_mode(wait_mode), .external_tick_pin(pin),
      .wrap_irq(wrap_irq));
   frt_tick_src u_src (.clk(clk), .go(go), .pin(pin));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      n_cyc++;
      if (n_cyc == 3000) begin
         n_errors++;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(logic [7:0] g, logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch t=%0t seen %h exp %h", $time, g, e);
      end
   endtask
   // one strobe cycle; a read compares the masked answer
   task automatic acc(logic w, logic [3:0] a, logic [7:0] d, logic [7:0] m = 8'hff);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
      if (!w) chk(rdata & m, d);
   endtask
   initial begin
      {nrst, wr, rd, go, wait_mode, addr, wdata} = '0;
      {irq_mask, halt_mode} = 2'b11;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      #1;
      acc(0, 4'h3, 8'hff);
      acc(0, 4'h4, 8'hfc);
      acc(1, 4'h4, 8'h00);
      acc(1, 4'h0, 8'h80);
      acc(0, 4'h6, 8'hfc);
      acc(1, 4'h6, 8'h00);
      acc(0, 4'h3, 8'hff);
      acc(0, 4'h5, 8'hff);
      acc(0, 4'h3, 8'hff);
      acc(0, 4'h6, 8'hfc);
      $display("test reset done");
      for (int s = 0; s < 5; s++) begin
         acc(1, 4'h1, CTL[s]);
         acc(1, 4'h4, 8'h00);
         wait_mode <= (s == 1);
         halt_mode <= 1'b0;
         go <= (s > 2);
         repeat (s < 3 ? 16 << s : 64) @(posedge clk);
         go <= 1'b0;
         if (s > 2) repeat (8) @(posedge clk);
         halt_mode <= 1'b1;
         #1;
         acc(0, 4'h3, 8'h00);
         acc(0, 4'h4, 8'h04);
         acc(0, 4'h2, 8'h20, 8'h20);
         chk(wrap_irq, 8'h00);
         irq_mask <= 1'b0;
         repeat (2) @(posedge clk);
         #1;
         chk(wrap_irq, 8'h01);
         acc(0, 4'h2, 8'h20, 8'h20);
         acc(0, 4'h6, 8'h04);
         acc(0, 4'h2, 8'h20, 8'h20);
         acc(0, 4'h4, 8'h04);
         acc(0, 4'h2, 8'h00, 8'h20);
         repeat (2) @(posedge clk);
         #1;
         chk(wrap_irq, 8'h00);
         irq_mask <= 1'b1;
         $display("test source %0d done", s);
      end
      conclude();
   end
endmodule // test_frt_timer
